// [debug_trigger_status_logic.sv]
`timescale 1ns/1ps

module debug_trigger_status_logic #(
  parameter int DEPTH = dbg_pkg::FIFO_DEPTH,
  parameter int WIDTH = dbg_pkg::FIFO_WIDTH
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire dbg_pkg::cpu_access_t cpu_acc,
  input  wire logic                 opcode_exec,
  input  wire logic [15:0]          comp_a_value,
  input  wire logic [15:0]          comp_b_value,
  input  wire logic                 secure,
  output logic                      armed_out,
  output logic                      trigger_event
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [3:0] CNT_FULL = 4'(DEPTH);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic                 en_q;
  logic [5:0]           cfg_q;
  logic [7:0]           trig_q;
  logic                 a_flag_q, b_flag_q, seq_q;
  logic [2:0]           pend_q, pend_d;
  logic [3:0]           cnt_q;
  logic [AW-1:0]        wr_ptr_q, rd_ptr_q, rd_ptr_d;
  logic [WIDTH-1:0]     rd_word, store_word;
  dbg_pkg::run_state_t  state_q, state_d;
  logic                 setup_ph, wr_done, rd_done, ctrl_wr;
  logic                 en_next, arm_next, run_start, stop_req, run_end, armed;
  logic                 a_rw_ok, b_rw_ok, hit_a, hit_b, hit_m;
  logic [2:0]           raw, qual;
  logic                 event_only, begin_trace, trig;
  logic                 store_evt, store_en, fifo_full;
  dbg_pkg::trig_mode_t  mode;

  // ************************************************************
  // APB decode
  // ************************************************************
  // Transfer phases
  assign setup_ph = psel & ~penable;
  assign wr_done  = psel & penable & pready & pwrite;
  assign rd_done  = psel & penable & pready & ~pwrite;
  assign ctrl_wr  = wr_done & (paddr == dbg_pkg::CTRL_OFS);

  // One wait-free access phase, error on unmapped offsets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & (paddr != dbg_pkg::CTRL_OFS) & (paddr != dbg_pkg::TRIG_OFS)
                 & (paddr != dbg_pkg::STAT_OFS) & (paddr != dbg_pkg::FIFO_OFS);
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= dbg_pkg::RDATA_RST;
    end else if (setup_ph) begin
      unique case (paddr)
        dbg_pkg::CTRL_OFS: prdata <= {24'h000000, en_q, armed, cfg_q};
        dbg_pkg::TRIG_OFS: prdata <= {24'h000000, trig_q};
        dbg_pkg::STAT_OFS: prdata <= {24'h000000, a_flag_q, b_flag_q, armed, 1'b0, cnt_q};
        dbg_pkg::FIFO_OFS: prdata <= {16'h0000, rd_word};
        default:           prdata <= dbg_pkg::RDATA_RST;
      endcase
    end
  end

  // ************************************************************
  // Control and setup registers
  // ************************************************************
  assign en_next   = pwdata[dbg_pkg::EN_BIT] & ~secure;
  assign arm_next  = pwdata[dbg_pkg::ARM_BIT] & en_next;
  assign run_start = ctrl_wr & arm_next & (state_q == dbg_pkg::RUN_IDLE);
  assign stop_req  = ctrl_wr & ~arm_next;
  assign armed     = (state_q != dbg_pkg::RUN_IDLE);

  // Enable and comparator qualifier bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q  <= dbg_pkg::CTRL_RST[dbg_pkg::EN_BIT];
      cfg_q <= dbg_pkg::CTRL_RST[5:0];
    end else if (ctrl_wr) begin
      en_q  <= en_next;
      cfg_q <= pwdata[5:0];
    end
  end

  // Setup register locked while armed, bits 4 and 5 held zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= dbg_pkg::TRIG_RST;
    end else if (wr_done && paddr == dbg_pkg::TRIG_OFS && !armed) begin
      trig_q <= pwdata[7:0] & dbg_pkg::TRIG_WMASK;
    end
  end

  // ************************************************************
  // Comparators and qualification
  // ************************************************************
  assign mode    = dbg_pkg::trig_mode_t'(trig_q[3:0]);
  assign a_rw_ok = ~cfg_q[dbg_pkg::A_RWEN_BIT] | (cfg_q[dbg_pkg::A_RW_BIT] == ~cpu_acc.write);
  assign b_rw_ok = ~cfg_q[dbg_pkg::B_RWEN_BIT] | (cfg_q[dbg_pkg::B_RW_BIT] == ~cpu_acc.write);
  assign hit_a   = cpu_acc.valid & (cpu_acc.addr == comp_a_value) & a_rw_ok;
  assign hit_b   = cpu_acc.valid & (cpu_acc.addr == comp_b_value) & b_rw_ok;

  // Combined hit of the data and range modes
  always_comb begin
    unique case (mode)
      dbg_pkg::MODE_A_AND_BD: hit_m = hit_a & (cpu_acc.data == comp_b_value[7:0]);
      dbg_pkg::MODE_A_NOT_BD: hit_m = hit_a & (cpu_acc.data != comp_b_value[7:0]);
      dbg_pkg::MODE_INSIDE:   hit_m = cpu_acc.valid & (cpu_acc.addr >= comp_a_value)
                                      & (cpu_acc.addr <= comp_b_value);
      dbg_pkg::MODE_OUTSIDE:  hit_m = cpu_acc.valid & ((cpu_acc.addr < comp_a_value)
                                      | (cpu_acc.addr > comp_b_value));
      default:                hit_m = 1'b0;
    endcase
  end

  assign raw = {hit_m, hit_b, hit_a};

  // Matches on fetches wait for the opcode to execute
  always_comb begin
    if (!trig_q[dbg_pkg::QSEL_BIT] || !armed) begin
      pend_d = 3'h0;
    end else if (cpu_acc.fetch) begin
      pend_d = raw;
    end else if (opcode_exec) begin
      pend_d = 3'h0;
    end else begin
      pend_d = pend_q;
    end
  end

  // Pending opcode matches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 3'h0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // Access match or executed-opcode match
  assign qual = trig_q[dbg_pkg::QSEL_BIT] ? (opcode_exec ? pend_q : 3'h0) : raw;

  // ************************************************************
  // Trigger mode decode
  // ************************************************************
  assign event_only  = (mode == dbg_pkg::MODE_EVT_B) | (mode == dbg_pkg::MODE_A_THEN_EB);
  assign begin_trace = trig_q[dbg_pkg::BEGIN_BIT] | event_only;

  always_comb begin
    unique case (mode)
      dbg_pkg::MODE_A_ONLY:    trig = qual[0];
      dbg_pkg::MODE_A_OR_B:    trig = qual[0] | qual[1];
      dbg_pkg::MODE_A_THEN_B:  trig = qual[1] & seq_q;
      dbg_pkg::MODE_EVT_B:     trig = qual[1];
      dbg_pkg::MODE_A_THEN_EB: trig = qual[1] & seq_q;
      dbg_pkg::MODE_A_AND_BD,
      dbg_pkg::MODE_A_NOT_BD,
      dbg_pkg::MODE_INSIDE,
      dbg_pkg::MODE_OUTSIDE:   trig = qual[2];
      default:                 trig = 1'b0;
    endcase
  end

  // A-seen latch for the sequential modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= 1'b0;
    end else if (run_start) begin
      seq_q <= 1'b0;
    end else if (armed && qual[0]) begin
      seq_q <= 1'b1;
    end
  end

  // Match flags, cleared only while idle at run start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_flag_q <= 1'b0;
      b_flag_q <= 1'b0;
    end else if (run_start) begin
      a_flag_q <= 1'b0;
      b_flag_q <= 1'b0;
    end else if (armed) begin
      a_flag_q <= a_flag_q | qual[0];
      b_flag_q <= b_flag_q | qual[1];
    end
  end

  // ************************************************************
  // Run sequencer
  // ************************************************************
  assign fifo_full  = (cnt_q == CNT_FULL - 4'h1) & store_en;
  assign store_evt  = event_only ? trig : cpu_acc.cof;
  assign store_en   = (state_q == dbg_pkg::RUN_STORE) & store_evt;
  assign store_word = event_only ? {8'h00, cpu_acc.data} : cpu_acc.addr;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dbg_pkg::RUN_IDLE: begin
        if (run_start) begin
          state_d = (begin_trace && !event_only) ? dbg_pkg::RUN_WAIT : dbg_pkg::RUN_STORE;
        end
      end
      dbg_pkg::RUN_WAIT: begin
        if (stop_req) begin
          state_d = dbg_pkg::RUN_IDLE;
        end else if (trig) begin
          state_d = dbg_pkg::RUN_STORE;
        end
      end
      dbg_pkg::RUN_STORE: begin
        if (stop_req) begin
          state_d = dbg_pkg::RUN_IDLE;
        end else if (begin_trace ? fifo_full : trig) begin
          state_d = dbg_pkg::RUN_IDLE;
        end
      end
    endcase
  end

  assign run_end = armed & (state_d == dbg_pkg::RUN_IDLE);

  // Sequencer state and armed image
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= dbg_pkg::RUN_IDLE;
      armed_out <= 1'b0;
    end else begin
      state_q   <= state_d;
      armed_out <= (state_d != dbg_pkg::RUN_IDLE) & (ctrl_wr ? en_next : en_q);
    end
  end

  // Trigger pulse while armed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_event <= 1'b0;
    end else begin
      trigger_event <= armed & trig;
    end
  end

  // ************************************************************
  // Trace storage and valid count
  // ************************************************************
  // Write pointer and saturating count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      cnt_q    <= dbg_pkg::CNT_RST;
    end else if (run_start) begin
      wr_ptr_q <= '0;
      cnt_q    <= dbg_pkg::CNT_RST;
    end else if (store_en) begin
      wr_ptr_q <= wr_ptr_q + AW'(1);
      cnt_q    <= (cnt_q == CNT_FULL) ? cnt_q : cnt_q + 4'h1;
    end
  end

  // Read pointer: oldest word at run end, advances on idle reads
  always_comb begin
    rd_ptr_d = rd_ptr_q;
    if (run_end) begin
      rd_ptr_d = (cnt_q == CNT_FULL || fifo_full) ? wr_ptr_q + AW'(store_en) : '0;
    end else if (rd_done && paddr == dbg_pkg::FIFO_OFS && !armed) begin
      rd_ptr_d = rd_ptr_q + AW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_q <= '0;
    end else begin
      rd_ptr_q <= rd_ptr_d;
    end
  end

  // Trace word memory
  trace_mem #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_trace_mem (
    .pclk      (pclk),
    .wr_en     (store_en),
    .wr_addr   (wr_ptr_q),
    .wr_data   (store_word),
    .rd_addr   (rd_ptr_d),
    .rd_data_q (rd_word)
  );

endmodule

// [dbg_pkg.sv]
package dbg_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] CTRL_OFS  = 12'h000;
  localparam logic [11:0] TRIG_OFS  = 12'h004;
  localparam logic [11:0] STAT_OFS  = 12'h008;
  localparam logic [11:0] FIFO_OFS  = 12'h00c;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int EN_BIT      = 7;  // Control: module enable
  localparam int ARM_BIT     = 6;  // Control: arm
  localparam int A_RW_BIT    = 3;  // Control: comparator A read/write value
  localparam int A_RWEN_BIT  = 2;  // Control: comparator A read/write enable
  localparam int B_RW_BIT    = 1;  // Control: comparator B read/write value
  localparam int B_RWEN_BIT  = 0;  // Control: comparator B read/write enable
  localparam int QSEL_BIT    = 7;  // Setup: qualify select
  localparam int BEGIN_BIT   = 6;  // Setup: begin trace select
  localparam int A_FLAG_BIT  = 7;  // Status: comparator A flag
  localparam int B_FLAG_BIT  = 6;  // Status: comparator B flag
  localparam int ARMED_BIT   = 5;  // Status: armed flag

  // ************************************************************
  // Reset values and masks
  // ************************************************************
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  TRIG_RST   = 8'h00;
  localparam logic [7:0]  TRIG_WMASK = 8'hcf;
  localparam logic [3:0]  CNT_RST    = 4'h0;
  localparam logic [31:0] RDATA_RST  = 32'h0000_0000;
  localparam int          FIFO_DEPTH = 8;
  localparam int          FIFO_WIDTH = 16;

  // ************************************************************
  // Trigger modes
  // ************************************************************
  typedef enum logic [3:0] {
    MODE_A_ONLY    = 4'h0,
    MODE_A_OR_B    = 4'h1,
    MODE_A_THEN_B  = 4'h2,
    MODE_EVT_B     = 4'h3,
    MODE_A_THEN_EB = 4'h4,
    MODE_A_AND_BD  = 4'h5,
    MODE_A_NOT_BD  = 4'h6,
    MODE_INSIDE    = 4'h7,
    MODE_OUTSIDE   = 4'h8
  } trig_mode_t;

  // Run sequencer states
  typedef enum logic [2:0] {
    RUN_IDLE  = 3'b001,
    RUN_WAIT  = 3'b010,
    RUN_STORE = 3'b100
  } run_state_t;

  // One monitored CPU bus cycle
  typedef struct packed {
    logic        valid;  // Bus cycle present
    logic        write;  // 1 write, 0 read
    logic        fetch;  // Opcode fetch cycle
    logic        cof;    // Change-of-flow address to trace
    logic [15:0] addr;
    logic [7:0]  data;
  } cpu_access_t;

endpackage

// [trace_mem.sv]
`timescale 1ns/1ps

// ************************************************************
// Trace word storage, registered read port
// ************************************************************
module trace_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             pclk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_q
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Write port
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Read port
  always_ff @(posedge pclk) begin
    rd_data_q <= mem_q[rd_addr];
  end

endmodule

// [debug_trigger_status_logic_assertions.sv]
`timescale 1ns/1ps

// ****************
// Port checker
// ****************
module dbg_port_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        secure,
  input wire logic        armed_out,
  input wire logic        trigger_event
);
  logic map_hit;
  logic ctrl_wr;
  logic rd_acc;

  // Decoded bus events
  assign map_hit = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);
  assign ctrl_wr = psel && penable && pready && pwrite && (paddr == dbg_pkg::CTRL_OFS);
  assign rd_acc  = psel && penable && pready && !pwrite;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no access cycle after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  chk_err_unmapped: assert property (pready |-> pslverr == !map_hit)
    else $error("error flag wrong for address");
  chk_arm_start: assert property (
    ctrl_wr && pwdata[dbg_pkg::EN_BIT] && pwdata[dbg_pkg::ARM_BIT] && !secure && !armed_out
    |=> armed_out)
    else $error("arm write did not start a run");
  chk_run_stop: assert property (ctrl_wr && !(pwdata[7] && pwdata[6]) |=> !armed_out)
    else $error("run not stopped by control write");
  chk_secure_block: assert property (ctrl_wr && secure |=> !armed_out)
    else $error("run started while secured");
  chk_setup_zero: assert property (
    rd_acc && paddr == dbg_pkg::TRIG_OFS |-> prdata[31:4] == {24'h0, prdata[7:6], 2'h0})
    else $error("setup reserved bits not zero");
  chk_count_range: assert property (
    rd_acc && paddr == dbg_pkg::STAT_OFS |-> prdata[3:0] <= 4'h8 && !prdata[4])
    else $error("status count out of range");
  chk_trig_armed: assert property (trigger_event |-> armed_out || $past(armed_out))
    else $error("trigger while not armed");
endmodule

bind debug_trigger_status_logic dbg_port_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .secure(secure), .armed_out(armed_out), .trigger_event(trigger_event)
);

// [cpu_bus_model.sv]
`timescale 1ns/1ps

// ****************
// CPU bus side model
// ****************
module cpu_bus_model (
  input  wire logic           pclk,
  output dbg_pkg::cpu_access_t acc,
  output logic                opcode_exec
);
  dbg_pkg::cpu_access_t last;

  // Quiet bus at time zero
  initial begin
    acc = '0;
    last = '0;
    opcode_exec = 1'b0;
  end

  // One bus cycle, then idle with lines inverted so no stale value lingers
  task automatic cyc(input logic [15:0] a, input logic w, f, c, input logic [7:0] d);
    @(posedge pclk);
    last = '{1'b1, w, f, c, a, d};
    acc <= last;
    @(posedge pclk);
    acc <= '{1'b0, ~last.write, 1'b0, 1'b0, ~last.addr, ~last.data};
  endtask

  // Executed opcode pulse
  task automatic exec_pulse;
    @(posedge pclk);
    opcode_exec <= 1'b1;
    @(posedge pclk);
    opcode_exec <= 1'b0;
  endtask
endmodule

// [tb_debug_trigger_status_logic.sv]
`timescale 1ns/1ps

module tb_debug_trigger_status_logic;
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  dbg_pkg::cpu_access_t cpu_acc;
  logic                 opcode_exec;
  logic                 secure = 1'b0;
  logic                 armed_out;
  logic                 trigger_event;
  logic [31:0]          rd;
  logic                 err;
  int                   error_cnt = 0;
  int                   n_tests = 0;
  int                   cycles = 0;
  logic [7:0]  t_su [13] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07,
                             8'h08, 8'h08, 8'h09, 8'h0f, 8'h80};
  logic [15:0] t_ad [13] = '{16'h1000, 16'h2000, 16'h2000, 16'h1000, 16'h1000, 16'h1000,
                             16'h1000, 16'h1800, 16'h1800, 16'h3000, 16'h1000, 16'h2000,
                             16'h1000};
  logic [12:0] t_ex = 13'h12a5;

  // ****************
  // Clock, reset, instances
  // ****************
  always #2.5 pclk = ~pclk;

  debug_trigger_status_logic dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_acc(cpu_acc), .opcode_exec(opcode_exec), .comp_a_value(16'h1000),
    .comp_b_value(16'h2000), .secure(secure), .armed_out(armed_out),
    .trigger_event(trigger_event)
  );

  cpu_bus_model cpu (.pclk(pclk), .acc(cpu_acc), .opcode_exec(opcode_exec));

  // Hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ****************
  // Shared tasks
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_end;
    for (int i = 0; i < 12 && armed_out; i++) @(posedge pclk);
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_regs;
    apb(1'b0, dbg_pkg::CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, dbg_pkg::TRIG_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, dbg_pkg::STAT_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, dbg_pkg::TRIG_OFS, 32'hff);
    apb(1'b0, dbg_pkg::TRIG_OFS, 32'h0);
    check(rd, 32'hcf);
    apb(1'b1, dbg_pkg::STAT_OFS, 32'hff);
    apb(1'b0, dbg_pkg::STAT_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask

  // Arm, one access, see whether the end trace stops
  task automatic trig_try(input logic [7:0] su, input logic [15:0] a, input logic ex,
                          input logic [31:0] stop);
    apb(1'b1, dbg_pkg::TRIG_OFS, {24'h0, su});
    apb(1'b1, dbg_pkg::CTRL_OFS, 32'hc0);
    cpu.cyc(a, 1'b0, su[7], 1'b0, 8'h00);
    if (su[7]) begin
      repeat (6) @(posedge pclk);
      check({31'h0, armed_out}, 32'h1);
      cpu.exec_pulse();
    end
    wait_end();
    check({31'h0, armed_out}, {31'h0, !ex});
    check({31'h0, trigger_event}, {31'h0, ex});
    if (!ex) begin
      apb(1'b1, dbg_pkg::TRIG_OFS, 32'h0a);
      apb(1'b0, dbg_pkg::TRIG_OFS, 32'h0);
      check(rd, {24'h0, su & 8'hcf});
    end
    apb(1'b1, dbg_pkg::CTRL_OFS, stop);
  endtask

  // Ten tagged bus cycles, optional end trigger, then status
  task automatic fill(input logic [7:0] su, input logic [15:0] a, input logic tr,
                      input logic [31:0] st);
    apb(1'b1, dbg_pkg::TRIG_OFS, {24'h0, su});
    apb(1'b1, dbg_pkg::CTRL_OFS, 32'hc0);
    apb(1'b0, dbg_pkg::STAT_OFS, 32'h0);
    check(rd, 32'h20);
    for (int i = 0; i < 10; i++) cpu.cyc(a, 1'b0, 1'b0, 1'b1, 8'ha0 + 8'(i));
    if (tr) cpu.cyc(16'h1000, 1'b0, 1'b0, 1'b0, 8'h00);
    wait_end();
    apb(1'b0, dbg_pkg::STAT_OFS, 32'h0);
    check(rd, st);
  endtask

  task automatic t_readout;
    int left;
    left = 8;
    while (left > 0) begin
      apb(1'b0, dbg_pkg::FIFO_OFS, 32'h0);
      check(rd, {24'h0, 8'ha0 + 8'(8 - left)});
      left--;
    end
    apb(1'b0, dbg_pkg::STAT_OFS, 32'h0);
    check(rd, 32'h48);
  endtask

  task automatic t_secure;
    secure <= 1'b1;
    apb(1'b1, dbg_pkg::CTRL_OFS, 32'hc0);
    apb(1'b0, dbg_pkg::CTRL_OFS, 32'h0);
    check({31'h0, rd[7]}, 32'h0);
    apb(1'b0, dbg_pkg::STAT_OFS, 32'h0);
    check(rd, 32'h48);
    secure <= 1'b0;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    for (int i = 0; i < 13; i++) trig_try(t_su[i], t_ad[i], t_ex[i], i[0] ? 32'h40 : 32'h80);
    fill(8'h41, 16'h2000, 1'b0, 32'h48);
    fill(8'h00, 16'h0050, 1'b1, 32'h88);
    fill(8'h03, 16'h2000, 1'b0, 32'h48);
    t_readout();
    t_secure();
    finish_test();
  end
endmodule
